// File: logic/tls_link_supervisor.sv
// 10 Mbit/s twisted-pair supervisor: Manchester coding, squelch, CRS/COL, jabber, link test, polarity, fiber detect.
`timescale 1ns/1ns
module tls_link_supervisor #(
    parameter int unsigned JABBER_CYC = tls_pkg::JABBER_MS * tls_pkg::CYC_PER_MS,
    parameter int unsigned UNJAB_CYC = tls_pkg::UNJAB_MS * tls_pkg::CYC_PER_MS,
    parameter int unsigned LP_PERIOD_CYC = tls_pkg::LP_PERIOD_MS * tls_pkg::CYC_PER_MS,
    parameter int unsigned LINK_LOSS_CYC = tls_pkg::LINK_LOSS_MS * tls_pkg::CYC_PER_MS
) (
    input wire logic ref_clk, // 50 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [7:0] reg_addr, // Byte address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    input wire logic mii_tx_en, // Transmit enable from MAC
    input wire logic mii_tx_bit, // Serial transmit data
    output logic tx_bit_take, // Pulse: mii_tx_bit taken
    output tls_pkg::tls_pair_s line_tx, // Line drivers, both low is idle
    input wire tls_pkg::tls_pair_s line_receive_pair, // Squelch comparators of the receive pair
    input wire logic line_rx_level, // Sliced receive level
    output logic low_squelch_sel, // Reduced squelch threshold select
    output logic rx_valid, // Qualified receive data valid
    output logic rx_bit, // Decoded receive bit
    output logic rx_bit_stb, // Pulse: rx_bit new
    output logic mii_crs, // Carrier sense
    output logic mii_col, // Collision
    output logic link_good, // Link integrity state
    input wire logic fiber_signal_detect_input, // Fiber transceiver detect pin
    input wire logic fiber_rx_clk, // Recovered fiber bit clock
    input wire logic fiber_rx_data, // Recovered fiber bit
    output logic signal_detect // Internal signal detect
);
    typedef enum logic [3:0] {
        RQ_IDLE = 4'b0001,
        RQ_FIRST = 4'b0010,
        RQ_SECOND = 4'b0100,
        RQ_VALID = 4'b1000
    } tls_rq_e;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_DATA = 4'b0010,
        TX_TAIL = 4'b0100,
        TX_PULSE = 4'b1000
    } tls_tx_e;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
        hit = (addr == {idx[5:0], 2'b00});
    endfunction : hit

    logic [15:0] config_reg;
    logic [15:0] fiber_reg;
    tls_pkg::tls_cfg_s cfg;
    logic pol_rev;
    logic jabbered;
    logic link_ok;
    logic tx_active;

    assign cfg.jabber_dis = config_reg[tls_pkg::CFG_JABBER_DIS];
    assign cfg.low_squelch = config_reg[tls_pkg::CFG_LOW_SQUELCH];
    assign cfg.full_duplex = config_reg[tls_pkg::CFG_FULL_DUPLEX];
    assign cfg.repeater = config_reg[tls_pkg::CFG_REPEATER];
    assign cfg.link_chk_dis = config_reg[tls_pkg::CFG_LINK_CHK_DIS];
    assign low_squelch_sel = cfg.low_squelch;
    assign link_ok = link_good | cfg.link_chk_dis;

    // Register writes
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            config_reg <= tls_pkg::CONFIG_RESET;
            fiber_reg <= tls_pkg::FIBER_RESET;
        end else if (reg_wr) begin
            if (hit(reg_addr, tls_pkg::IDX_CONFIG)) begin
                config_reg <= reg_wdata;
            end
            if (hit(reg_addr, tls_pkg::IDX_FIBER)) begin
                fiber_reg <= reg_wdata;
            end
        end
    end

    // Register reads; unmapped reads return zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            if (hit(reg_addr, tls_pkg::IDX_CONFIG)) begin
                reg_rdata <= config_reg;
            end
            if (hit(reg_addr, tls_pkg::IDX_STATUS)) begin
                reg_rdata[tls_pkg::STS_LINK_GOOD] <= link_good;
                reg_rdata[tls_pkg::STS_JABBER] <= jabbered;
                reg_rdata[tls_pkg::STS_RX_VALID] <= rx_valid;
                reg_rdata[tls_pkg::STS_POL_REV] <= pol_rev;
            end
            if (hit(reg_addr, tls_pkg::IDX_FIBER)) begin
                reg_rdata[tls_pkg::FIB_SOURCE_SEL_N] <= fiber_reg[tls_pkg::FIB_SOURCE_SEL_N];
                reg_rdata[tls_pkg::FIB_SIGNAL] <= signal_detect;
            end
        end
    end

    // Three-stage input synchronisers; filtered value moves once stages two and three agree
    localparam int unsigned NSYNC = 6;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [NSYNC-1:0] sync_c;
    logic [NSYNC-1:0] filt;
    assign async_in = {fiber_rx_data, fiber_rx_clk, fiber_signal_detect_input,
                       line_rx_level, line_receive_pair.neg, line_receive_pair.pos};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_c[gi] <= 1'b0;
                    filt[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= async_in[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                    if (sync_b[gi] == sync_c[gi]) begin
                        filt[gi] <= sync_c[gi];
                    end
                end
            end
        end
    endgenerate

    // Polarity correction swaps the comparators and inverts the level
    logic sq_pos;
    logic sq_neg;
    logic rx_lvl;
    assign sq_pos = pol_rev ? filt[1] : filt[0];
    assign sq_neg = pol_rev ? filt[0] : filt[1];
    assign rx_lvl = filt[2] ^ pol_rev;

    // Fiber signal detect from a run of recovered ones, or from the detect pin when FIB_SOURCE_SEL_N is set
    logic fclk_d;
    logic [6:0] ones_cnt;
    logic [6:0] zeros_cnt;
    logic run_detect;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fclk_d <= 1'b0;
            ones_cnt <= '0;
            zeros_cnt <= '0;
            run_detect <= 1'b0;
        end else begin
            fclk_d <= filt[4];
            if (filt[4] && !fclk_d) begin
                if (filt[5]) begin
                    zeros_cnt <= '0;
                    if (ones_cnt == 7'(tls_pkg::ONES_RUN - 1)) begin
                        run_detect <= 1'b1;
                    end else begin
                        ones_cnt <= ones_cnt + 7'd1;
                    end
                end else begin
                    ones_cnt <= '0;
                    // Loss needs an equally long run of zeros, so data bits do not flap it
                    if (zeros_cnt == 7'(tls_pkg::ONES_RUN - 1)) begin
                        run_detect <= 1'b0;
                    end else begin
                        zeros_cnt <= zeros_cnt + 7'd1;
                    end
                end
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            signal_detect <= 1'b0;
        end else begin
            signal_detect <= fiber_reg[tls_pkg::FIB_SOURCE_SEL_N] ? filt[3] : run_detect;
        end
    end

    // Receive qualification
    tls_rq_e rq_state;
    logic first_neg;
    logic last_neg;
    logic [3:0] win_cnt;
    logic [3:0] quiet_cnt;
    logic [3:0] edge_cnt;
    logic rx_lvl_d;
    logic lp_seen;
    logic lp_inv;
    logic eop_seen;
    logic eop_inv;
    logic sq_first;
    logic sq_opp;
    assign sq_first = first_neg ? sq_neg : sq_pos;
    assign sq_opp = first_neg ? sq_pos : sq_neg;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rq_state <= RQ_IDLE;
            first_neg <= 1'b0;
            last_neg <= 1'b0;
            win_cnt <= '0;
            quiet_cnt <= '0;
            lp_seen <= 1'b0;
            lp_inv <= 1'b0;
            eop_seen <= 1'b0;
            eop_inv <= 1'b0;
        end else begin
            lp_seen <= 1'b0;
            eop_seen <= 1'b0;
            win_cnt <= win_cnt + 4'd1;
            unique case (rq_state)
                RQ_IDLE: begin
                    win_cnt <= '0;
                    if (sq_pos || sq_neg) begin
                        first_neg <= sq_neg && !sq_pos;
                        rq_state <= RQ_FIRST;
                    end
                end
                RQ_FIRST: begin
                    if (sq_opp) begin
                        win_cnt <= '0;
                        rq_state <= RQ_SECOND;
                    end else if (win_cnt >= 4'(tls_pkg::SQ_WIN_CYC)) begin
                        // Lone pulse with no opposite swing counts as a link pulse
                        lp_seen <= 1'b1;
                        lp_inv <= first_neg;
                        rq_state <= RQ_IDLE;
                    end
                end
                RQ_SECOND: begin
                    if (sq_first && !sq_opp) begin
                        quiet_cnt <= '0;
                        rq_state <= RQ_VALID;
                    end else if (win_cnt >= 4'(tls_pkg::SQ_WIN_CYC)) begin
                        rq_state <= RQ_IDLE;
                    end
                end
                RQ_VALID: begin
                    if (sq_pos || sq_neg) begin
                        quiet_cnt <= '0;
                        last_neg <= sq_neg && !sq_pos;
                    end else begin
                        quiet_cnt <= quiet_cnt + 4'd1;
                    end
                    if (quiet_cnt >= 4'(tls_pkg::QUIET_CYC)) begin
                        eop_seen <= 1'b1;
                        eop_inv <= last_neg;
                        rq_state <= RQ_IDLE;
                    end else if (edge_cnt >= 4'(tls_pkg::EOF_CYC)) begin
                        // Edges ceased well before squelch quiet, so this is the usual packet end
                        eop_seen <= 1'b1;
                        eop_inv <= last_neg;
                        rq_state <= RQ_IDLE;
                    end
                end
            endcase
        end
    end

    // Manchester decode: a transition at least a full bit (five clocks) after the last accepted one is mid-bit
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_lvl_d <= 1'b0;
            edge_cnt <= '0;
            rx_bit <= 1'b0;
            rx_bit_stb <= 1'b0;
        end else begin
            rx_lvl_d <= rx_lvl;
            rx_bit_stb <= 1'b0;
            if (rq_state != RQ_VALID) begin
                edge_cnt <= '0;
            end else if (rx_lvl != rx_lvl_d && edge_cnt >= 4'(tls_pkg::EDGE_GUARD_CYC)) begin
                edge_cnt <= '0;
                rx_bit <= rx_lvl;
                rx_bit_stb <= link_ok;
            end else if (edge_cnt != 4'hf) begin
                edge_cnt <= edge_cnt + 4'd1;
            end
        end
    end

    assign rx_valid = (rq_state == RQ_VALID) && link_ok;

    // Polarity detection over link pulses and end-of-packet pulses
    logic [2:0] lp_inv_cnt;
    logic [1:0] eop_inv_cnt;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pol_rev <= 1'b0;
            lp_inv_cnt <= '0;
            eop_inv_cnt <= '0;
        end else if (lp_seen) begin
            if (!lp_inv) begin
                lp_inv_cnt <= '0;
            end else if (lp_inv_cnt == 3'(tls_pkg::LP_INV_LIMIT - 1)) begin
                pol_rev <= !pol_rev;
                lp_inv_cnt <= '0;
                eop_inv_cnt <= '0;
            end else begin
                lp_inv_cnt <= lp_inv_cnt + 3'd1;
            end
        end else if (eop_seen) begin
            if (!eop_inv) begin
                eop_inv_cnt <= '0;
            end else if (eop_inv_cnt == 2'(tls_pkg::EOP_INV_LIMIT - 1)) begin
                pol_rev <= !pol_rev;
                lp_inv_cnt <= '0;
                eop_inv_cnt <= '0;
            end else begin
                eop_inv_cnt <= eop_inv_cnt + 2'd1;
            end
        end
    end

    // Link integrity; any link pulse or packet restarts the loss timer
    logic [31:0] loss_cnt;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            link_good <= 1'b0;
            loss_cnt <= '0;
        end else if (lp_seen || eop_seen) begin
            link_good <= 1'b1;
            loss_cnt <= '0;
        end else if (loss_cnt >= LINK_LOSS_CYC - 1) begin
            link_good <= 1'b0;
        end else begin
            loss_cnt <= loss_cnt + 32'd1;
        end
    end

    // Jabber and un-jab timers
    logic [31:0] jab_cnt;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            jabbered <= 1'b0;
            jab_cnt <= '0;
        end else if (cfg.jabber_dis) begin
            jabbered <= 1'b0;
            jab_cnt <= '0;
        end else if (!jabbered) begin
            if (!mii_tx_en) begin
                jab_cnt <= '0;
            end else if (jab_cnt >= JABBER_CYC) begin
                jabbered <= 1'b1;
                jab_cnt <= '0;
            end else begin
                jab_cnt <= jab_cnt + 32'd1;
            end
        end else if (mii_tx_en) begin
            jab_cnt <= '0;
        end else if (jab_cnt >= UNJAB_CYC - 1) begin
            jabbered <= 1'b0;
            jab_cnt <= '0;
        end else begin
            jab_cnt <= jab_cnt + 32'd1;
        end
    end

    // Transmit: bit-rate enable, Manchester encoder, idle tail and link pulses
    tls_tx_e tx_state;
    logic [2:0] phase;
    logic [31:0] lp_cnt;
    logic [4:0] tail_cnt;
    logic cur_bit;
    logic tx_go;
    assign tx_go = mii_tx_en && link_ok && !jabbered;
    assign tx_active = (tx_state == TX_DATA);
    assign tx_bit_take = (tx_state == TX_DATA || tx_state == TX_IDLE) && tx_go && (phase == '0);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phase <= '0;
        end else if (tx_state != TX_DATA && !tx_go) begin
            phase <= '0;
        end else if (phase == 3'(tls_pkg::BIT_CYC - 1)) begin
            phase <= '0;
        end else begin
            phase <= phase + 3'd1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tx_state <= TX_IDLE;
            cur_bit <= 1'b0;
            tail_cnt <= '0;
            lp_cnt <= '0;
            line_tx <= '0;
        end else begin
            unique case (tx_state)
                TX_IDLE: begin
                    line_tx <= '0;
                    lp_cnt <= lp_cnt + 32'd1;
                    if (tx_bit_take) begin
                        cur_bit <= mii_tx_bit;
                        line_tx <= {!mii_tx_bit, mii_tx_bit};
                        tx_state <= TX_DATA;
                    end else if (lp_cnt >= LP_PERIOD_CYC - 1) begin
                        lp_cnt <= '0;
                        tail_cnt <= '0;
                        tx_state <= TX_PULSE;
                    end
                end
                TX_DATA: begin
                    lp_cnt <= '0;
                    tail_cnt <= '0;
                    // Bits are taken at the boundary, in step with tx_bit_take
                    if (phase == '0) begin
                        if (tx_go) begin
                            cur_bit <= mii_tx_bit;
                            line_tx <= {!mii_tx_bit, mii_tx_bit};
                        end else begin
                            // Ends high: a one ends on its mid-cell edge, a zero gets a boundary edge
                            line_tx <= 2'b10;
                            tx_state <= TX_TAIL;
                        end
                    end else if (phase == 3'(tls_pkg::MID_CYC - 1)) begin
                        line_tx <= {cur_bit, !cur_bit};
                    end
                end
                TX_TAIL: begin
                    tail_cnt <= tail_cnt + 5'd1;
                    if (tail_cnt >= 5'(tls_pkg::TAIL_CYC - 1)) begin
                        line_tx <= '0;
                        tx_state <= TX_IDLE;
                    end
                end
                TX_PULSE: begin
                    line_tx <= 2'b10;
                    tail_cnt <= tail_cnt + 5'd1;
                    if (tail_cnt >= 5'(tls_pkg::LP_WIDTH_CYC)) begin
                        line_tx <= '0;
                        tx_state <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Carrier sense and collision
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mii_crs <= 1'b0;
            mii_col <= 1'b0;
        end else if (cfg.full_duplex || cfg.repeater) begin
            mii_crs <= rx_valid;
            mii_col <= 1'b0;
        end else begin
            mii_crs <= rx_valid || tx_active;
            mii_col <= (mii_tx_en && rx_valid) || (jabbered && mii_tx_en);
        end
    end
endmodule : tls_link_supervisor

// File: logic/tls_pkg.sv
// Constants, register map and carrier types for the 10 Mbit/s link supervisor.
package tls_pkg;
    // Clock and timing figures
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned BIT_NS = 100;
    localparam int unsigned SQ_WIN_NS = 150;
    localparam int unsigned QUIET_NS = 200;
    localparam int unsigned EOF_NS = 150;
    localparam int unsigned LP_WIDTH_NS = 100;
    localparam int unsigned JABBER_MS = 24;
    localparam int unsigned UNJAB_MS = 408;
    localparam int unsigned LP_PERIOD_MS = 16;
    localparam int unsigned LINK_LOSS_MS = 100;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    // Least times round up, longest times round down
    localparam int unsigned BIT_CYC = BIT_NS / CLK_NS;
    localparam int unsigned MID_CYC = (BIT_CYC + 1) / 2;
    localparam int unsigned SQ_WIN_CYC = SQ_WIN_NS / CLK_NS;
    localparam int unsigned QUIET_CYC = (QUIET_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned EOF_CYC = EOF_NS / CLK_NS;
    localparam int unsigned LP_WIDTH_CYC = (LP_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TAIL_CYC = 2 * BIT_CYC;
    localparam int unsigned EDGE_GUARD_CYC = MID_CYC + 1;
    localparam int unsigned ONES_RUN = 65;
    localparam int unsigned LP_INV_LIMIT = 7;
    localparam int unsigned EOP_INV_LIMIT = 3;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CONFIG = 8'h10;
    localparam logic [7:0] IDX_STATUS = 8'h11;
    localparam logic [7:0] IDX_FIBER = 8'h12;
    // Field positions
    localparam int unsigned CFG_JABBER_DIS = 0;
    localparam int unsigned CFG_LOW_SQUELCH = 7;
    localparam int unsigned CFG_FULL_DUPLEX = 8;
    localparam int unsigned CFG_REPEATER = 9;
    localparam int unsigned CFG_LINK_CHK_DIS = 10;
    localparam int unsigned STS_LINK_GOOD = 0;
    localparam int unsigned STS_JABBER = 1;
    localparam int unsigned STS_RX_VALID = 2;
    localparam int unsigned STS_POL_REV = 13;
    localparam int unsigned FIB_SOURCE_SEL_N = 0;
    localparam int unsigned FIB_SIGNAL = 1;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] FIBER_RESET = 16'h0000;

    typedef struct packed {
        logic link_chk_dis;
        logic repeater;
        logic full_duplex;
        logic low_squelch;
        logic jabber_dis;
    } tls_cfg_s;

    typedef struct packed {
        logic pos;
        logic neg;
    } tls_pair_s;
endpackage : tls_pkg

// File: tb/tls_sva.sv
// Port checker for the link supervisor
`timescale 1ns/1ns
module tls_sva (
    input wire logic ref_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [7:0] reg_addr, // Address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [15:0] reg_rdata, // Read data
    input wire logic mii_tx_en, // Tx enable
    input wire logic mii_tx_bit, // Tx bit
    input wire logic tx_bit_take, // Bit taken
    input wire tls_pkg::tls_pair_s line_tx, // Line drive
    input wire logic rx_valid, // Rx valid
    input wire logic mii_crs, // Carrier
    input wire logic mii_col, // Collision
    input wire logic low_squelch_sel // Squelch select
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_col_cause: assert property (mii_col |-> $past(mii_tx_en)) else $error("collision without tx enable");
    a_crs_rx: assert property (rx_valid |=> mii_crs) else $error("carrier missing on receive");
    a_take_gap: assert property (tx_bit_take |=> !tx_bit_take [*4]) else $error("bit taken too soon");
    a_take_en: assert property (tx_bit_take |-> mii_tx_en) else $error("bit taken while idle");
    a_manch_cell: assert property (tx_bit_take |=> line_tx == {!$past(mii_tx_bit), $past(mii_tx_bit)}
        ##3 line_tx == {$past(mii_tx_bit, 4), !$past(mii_tx_bit, 4)}) else $error("bad cell");
    a_squelch_cfg: assert property (reg_wr && reg_addr == 8'h40 |=> low_squelch_sel == $past(reg_wdata[7]))
        else $error("squelch select wrong");
    a_crs_end: assert property ((!rx_valid && !mii_tx_en && line_tx == 2'b00) [*2] |=> !mii_crs)
        else $error("carrier held");
    a_hole_zero: assert property (reg_rd && reg_addr == 8'h4C |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule : tls_sva
bind tls_link_supervisor tls_sva u_sva (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .mii_tx_en, .mii_tx_bit, .tx_bit_take, .line_tx, .rx_valid, .mii_crs, .mii_col, .low_squelch_sel);

// File: tb/tls_peer.sv
// Remote station driving the receive pair
`timescale 1ns/1ns
module tls_peer (
    output tls_pkg::tls_pair_s sq, // Squelch pair
    output logic lvl // Sliced level
);
    initial begin
        sq = 2'b00;
        lvl = 1'b0;
    end
    task automatic half(input logic v);
        sq = {v, !v};
        lvl = v;
        #50;
    endtask : half
    // Idle line shows the inverse level, never the last one
    task automatic pulse(input logic inv);
        sq = {!inv, inv};
        lvl = !inv;
        #100;
        sq = 2'b00;
        lvl = inv;
        #2000;
    endtask : pulse
    task automatic frame(input int n);
        for (int i = 0; i < n; i++) begin
            half(!i[0]);
            half(i[0]);
        end
        sq = 2'b00;
        lvl = !lvl;
        #1000;
    endtask : frame
endmodule : tls_peer

// File: tb/tls_link_supervisor_tb_top.sv
// Self-checking bench for the link supervisor
`timescale 1ns/1ns
module tls_link_supervisor_tb_top;
    logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, lvl, rx_valid, mii_col, tx_bit_take;
    logic mii_tx_en = 0, mii_tx_bit = 0, fib_clk = 0, fib_dat = 0, fib_pin = 0, signal_detect;
    logic [7:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, v;
    logic mii_crs, link_good, low_squelch_sel, rx_bit, rx_bit_stb, last_bit = 0, got_bit = 0;
    tls_pkg::tls_pair_s sq, line_tx;
    logic [31:0] exp_q[$];
    int fails = 0, num_checks = 0, seed = 29, nbits = 0, tx_hi = 0, k;
    initial forever #10 ref_clk = !ref_clk;
    tls_peer peer (.sq(sq), .lvl(lvl));
    tls_link_supervisor #(.JABBER_CYC(200), .UNJAB_CYC(300), .LP_PERIOD_CYC(100), .LINK_LOSS_CYC(1000)) dut (
        .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mii_tx_en, .mii_tx_bit,
        .tx_bit_take, .line_tx, .line_receive_pair(sq), .line_rx_level(lvl), .low_squelch_sel, .rx_valid,
        .rx_bit, .rx_bit_stb, .mii_crs, .mii_col, .link_good, .fiber_signal_detect_input(fib_pin),
        .fiber_rx_clk(fib_clk), .fiber_rx_data(fib_dat), .signal_detect);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        exp_q.push_back({m, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task automatic send(input int n);
        mii_tx_en <= 1'b1;
        mii_tx_bit <= 1'($random(seed));
        repeat (n * 5 + 2) begin
            @(posedge ref_clk);
            if (tx_bit_take === 1'b1) mii_tx_bit <= 1'($random(seed));
        end
        mii_tx_en <= 1'b0;
        @(posedge ref_clk);
    endtask : send
    // Read data stand from the cycle after the strobe until the next read, and are checked there
    always @(posedge ref_clk) begin
        logic [31:0] e;
        if (rd_d) begin
            e = exp_q.pop_front();
            chk(reg_rdata & e[31:16], e[15:0]);
        end
        rd_d <= reg_rd;
    end
    // Test frames carry alternating bits; idle line high counts link pulses
    always @(posedge ref_clk) begin
        if (rx_bit_stb === 1'b1) begin
            if (got_bit) chk({15'h0000, rx_bit}, {15'h0000, !last_bit});
            last_bit <= rx_bit;
            got_bit <= 1'b1;
            nbits++;
        end
        if (line_tx == 2'b10) tx_hi++;
    end
    initial begin
        #400000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(8'h40, 16'hFFFF, 16'h0000);
        v = 16'($random(seed)) & 16'h0781;
        wr(8'h40, v);
        chk({15'h0000, low_squelch_sel}, {15'h0000, v[7]});
        rd(8'h40, 16'h0781, v);
        rd(8'h4C, 16'hFFFF, 16'h0000);
        wr(8'h40, 16'h0000);
        peer.pulse(1'b0);
        @(posedge ref_clk);
        rd(8'h44, 16'h0001, 16'h0001);
        chk({15'h0000, link_good}, 16'h0001);
        wr(8'h40, 16'h0100);
        fork
            peer.frame(20);
            send(30);
            begin
                repeat (60) @(negedge ref_clk);
                chk({15'h0000, mii_col}, 16'h0000);
                chk({15'h0000, mii_crs}, 16'h0001);
                repeat (70) @(negedge ref_clk);
                chk({15'h0000, mii_crs}, 16'h0000);
            end
        join
        chk({15'h0000, nbits >= 15}, 16'h0001);
        wr(8'h40, 16'h0000);
        fork
            peer.frame(40);
            send(60);
            begin
                repeat (150) @(negedge ref_clk);
                chk({15'h0000, mii_col}, 16'h0001);
            end
        join
        repeat (7) peer.pulse(1'b1);
        @(posedge ref_clk);
        rd(8'h44, 16'h2000, 16'h2000);
        send(52);
        rd(8'h44, 16'h0002, 16'h0002);
        k = tx_hi;
        repeat (320) @(posedge ref_clk);
        chk({15'h0000, tx_hi > k}, 16'h0001);
        rd(8'h44, 16'h0002, 16'h0000);
        fib_pin <= 1'b1;
        for (int i = 0; i < 65; i++) begin
            if (i == 64) begin
                repeat (8) @(negedge ref_clk);
                chk({15'h0000, signal_detect}, 16'h0000);
            end
            fib_dat = 1'b1;
            #83 fib_clk = 1'b1;
            #77 fib_clk = 1'b0;
        end
        repeat (8) @(negedge ref_clk);
        chk({15'h0000, signal_detect}, 16'h0001);
        @(posedge ref_clk);
        rd(8'h48, 16'h0002, 16'h0002);
        end_of_test();
    end
endmodule : tls_link_supervisor_tb_top
